// *** src/swo_pkg.sv ***
// Constants shared by the sleep, watchdog and option block
package swo_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WDT_TIMEOUT_MS = 12;
  localparam int unsigned WDT_TIMEOUT_CYC = WDT_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int unsigned POR_DELAY_MS = 20;
  localparam int unsigned POR_DELAY_CYC = POR_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned EXTRA_XTAL_CYC = 18;
  localparam logic [15:0] STOP_RECOVERY_VECTOR = 16'h000c;
  localparam logic [7:0] OP_NOP = 8'hff;
  localparam logic [7:0] OP_STOP = 8'h6f;
  localparam logic [7:0] OP_HALT = 8'h7f;
  localparam logic [7:0] OP_WATCHDOG_REFRESH = 8'h5f;
  localparam logic [7:0] OP_HALT_WATCHDOG_ENABLE = 8'h4f;
  localparam int unsigned FLAG_Z_POS = 2;
  localparam int unsigned FLAG_S_POS = 1;
  localparam int unsigned FLAG_V_POS = 0;
  localparam int unsigned PORT2_MODE_TOP_POS = 7;
endpackage

// *** src/swo_wdt_if.sv ***
// Watchdog control carrier between top and counter
`timescale 1ns/100ps
interface swo_wdt_if;
  logic run;
  logic clear;
  logic expired;
  modport ctl (output run, output clear, input expired);
  modport cnt (input run, input clear, output expired);
endinterface

// *** src/swo_wdt_counter.sv ***
// Watchdog period counter
`timescale 1ns/100ps
module swo_wdt_counter #(
  parameter int unsigned TIMEOUT_CYC = swo_pkg::WDT_TIMEOUT_CYC
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  swo_wdt_if.cnt wdt
);
  logic [31:0] count;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= 32'h0;
      wdt.expired <= 1'b0;
    end else if (wdt.clear) begin
      count <= 32'h0;
      wdt.expired <= 1'b0;
    end else if (wdt.run) begin
      // Pulse once at the end of a full period, then restart
      if (count >= TIMEOUT_CYC - 1) begin
        count <= 32'h0;
        wdt.expired <= 1'b1;
      end else begin
        count <= count + 32'h1;
        wdt.expired <= 1'b0;
      end
    end else begin
      wdt.expired <= 1'b0;
    end
  end
endmodule

// *** src/swo_sleep_watchdog.sv ***
// Stop mode, watchdog, reset sequencing and option bits
`timescale 1ns/100ps
module swo_sleep_watchdog #(
  parameter int unsigned WDT_TIMEOUT_CYC = swo_pkg::WDT_TIMEOUT_CYC,
  parameter int unsigned POR_DELAY_CYC = swo_pkg::POR_DELAY_CYC,
  parameter int unsigned EXTRA_XTAL_CYC = swo_pkg::EXTRA_XTAL_CYC
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic op_valid_in,
  input wire logic [7:0] op_code_in,
  input wire logic port2_mode_top_in,
  input wire logic stop_recovery_pin_in,
  input wire logic low_voltage_in,
  input wire logic opt_permanent_wdt_in,
  input wire logic opt_low_noise_in,
  input wire logic opt_read_protect_in,
  input wire logic opt_latch_disable_in,
  input wire logic opt_prog_disable_in,
  input wire logic program_mode_select_in,
  input wire logic osc_in_pin_in,
  input wire logic output_enable_pin_in,
  input wire logic supply_pin_in,
  input wire logic strobe_pin_in,
  input wire logic ext_read_req_in,
  input wire logic internal_load_req_in,
  output logic core_clk_en_out,
  output logic osc_enable_out,
  output logic stopped_out,
  output logic halted_out,
  output logic core_reset_out,
  output logic port_mode_default_out,
  output logic fetch_load_out,
  output logic [15:0] fetch_addr_out,
  output logic flags_load_out,
  output logic [2:0] flags_value_out,
  output logic watchdog_enabled_out,
  output logic low_noise_out,
  output logic ext_read_grant_out,
  output logic internal_load_grant_out,
  output logic latch_enable_out,
  output logic program_mode_out,
  output logic chip_enable_out,
  output logic prog_output_enable_out,
  output logic program_strobe_out,
  output logic program_supply_out
);
  typedef enum {SWO_RUN, SWO_HALT, SWO_STOP, SWO_RESET} swo_state_e;

  swo_state_e state;
  logic wdt_on;
  logic halt_wdt;
  logic prog_locked;
  logic strap_done;
  logic [31:0] rst_count;
  logic stop_wake;
  logic div2;
  logic nop_seen;
  logic is_refresh;
  logic reset_cause;
  swo_wdt_if wdt();

  assign is_refresh = op_valid_in && op_code_in == swo_pkg::OP_WATCHDOG_REFRESH
    && state == SWO_RUN;
  assign stop_wake = state == SWO_STOP && !stop_recovery_pin_in;
  assign reset_cause = low_voltage_in || wdt.expired;

  swo_wdt_counter #(
    .TIMEOUT_CYC(WDT_TIMEOUT_CYC)
  ) u_counter (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .wdt(wdt)
  );

  // Sleep state machine; nop before sleep is trusted to software
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= SWO_RESET;
      nop_seen <= 1'b0;
    end else if (reset_cause) begin
      state <= SWO_RESET;
      nop_seen <= 1'b0;
    end else begin
      if (op_valid_in) begin
        nop_seen <= op_code_in == swo_pkg::OP_NOP;
      end
      unique case (state)
        SWO_RUN: begin
          if (op_valid_in && op_code_in == swo_pkg::OP_STOP) begin
            state <= SWO_STOP;
          end else if (op_valid_in && op_code_in == swo_pkg::OP_HALT) begin
            state <= SWO_HALT;
          end
        end
        SWO_HALT: begin
          // Interrupt wake lives elsewhere; a low stop pin also wakes it, but only while port2_mode_top_in is high
          if (!stop_recovery_pin_in && port2_mode_top_in) begin
            state <= SWO_RUN;
          end
        end
        SWO_STOP: begin
          if (stop_wake) begin
            state <= SWO_RUN;
          end
        end
        SWO_RESET: begin
          if (rst_count >= POR_DELAY_CYC + EXTRA_XTAL_CYC - 1) begin
            state <= SWO_RUN;
          end
        end
      endcase
    end
  end

  // Power-on style delay: full delay plus extra crystal cycles
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_count <= 32'h0;
    end else if (reset_cause || state != SWO_RESET) begin
      rst_count <= 32'h0;
    end else begin
      rst_count <= rst_count + 32'h1;
    end
  end

  // Enable is sticky until reset
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wdt_on <= 1'b0;
      halt_wdt <= 1'b0;
    end else if (reset_cause || state == SWO_RESET) begin
      wdt_on <= 1'b0;
      halt_wdt <= 1'b0;
    end else begin
      if (is_refresh) begin
        wdt_on <= 1'b1;
      end
      if (op_valid_in && state == SWO_RUN && wdt_on
          && op_code_in == swo_pkg::OP_HALT_WATCHDOG_ENABLE) begin
        halt_wdt <= 1'b1;
      end
    end
  end

  // Counter steering
  always_comb begin
    wdt.clear = is_refresh || state == SWO_RESET;
    if (state == SWO_RESET) begin
      wdt.run = 1'b0;
    end else if (opt_permanent_wdt_in) begin
      wdt.run = 1'b1;
    end else if (!wdt_on) begin
      wdt.run = 1'b0;
    end else begin
      unique case (state)
        SWO_STOP: wdt.run = 1'b0;
        SWO_HALT: wdt.run = halt_wdt;
        default: wdt.run = 1'b1;
      endcase
    end
  end

  // Divide-by-two enable, bypassed in low noise
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div2 <= 1'b0;
    end else begin
      div2 <= ~div2;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_clk_en_out <= 1'b0;
      osc_enable_out <= 1'b1;
      stopped_out <= 1'b0;
      halted_out <= 1'b0;
      core_reset_out <= 1'b1;
    end else begin
      core_clk_en_out <= state == SWO_RUN
        && (opt_low_noise_in || div2);
      osc_enable_out <= state != SWO_STOP;
      stopped_out <= state == SWO_STOP;
      halted_out <= state == SWO_HALT;
      core_reset_out <= state == SWO_RESET || reset_cause;
    end
  end

  // Recovery vector and port mode handling
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fetch_load_out <= 1'b0;
      fetch_addr_out <= 16'h0;
      port_mode_default_out <= 1'b1;
    end else begin
      fetch_load_out <= stop_wake && !reset_cause;
      fetch_addr_out <= swo_pkg::STOP_RECOVERY_VECTOR;
      // Keeping modes avoids output glitches across stop recovery
      port_mode_default_out <= state == SWO_RESET || reset_cause;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_load_out <= 1'b0;
      flags_value_out <= 3'h0;
      watchdog_enabled_out <= 1'b0;
    end else begin
      flags_load_out <= is_refresh;
      flags_value_out <= 3'h4;
      // First refresh shows enabled with its flag pulse, not one cycle later
      watchdog_enabled_out <= wdt_on || is_refresh
        || (opt_permanent_wdt_in && state != SWO_RESET);
    end
  end

  // Program lock is caught once after reset release, so it acts per power cycle
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prog_locked <= 1'b1;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      prog_locked <= opt_prog_disable_in;
      strap_done <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_noise_out <= 1'b0;
      ext_read_grant_out <= 1'b0;
      internal_load_grant_out <= 1'b0;
      latch_enable_out <= 1'b0;
      program_mode_out <= 1'b0;
      chip_enable_out <= 1'b0;
      prog_output_enable_out <= 1'b0;
      program_strobe_out <= 1'b0;
      program_supply_out <= 1'b0;
    end else begin
      low_noise_out <= opt_low_noise_in;
      ext_read_grant_out <= ext_read_req_in && !opt_read_protect_in
        && program_mode_select_in && strap_done && !prog_locked;
      internal_load_grant_out <= internal_load_req_in;
      latch_enable_out <= !opt_latch_disable_in;
      program_mode_out <= program_mode_select_in && strap_done && !prog_locked;
      // Pin remap: active-low strobes and an active-high supply seen through the programming pins
      chip_enable_out <= program_mode_select_in && strap_done && !prog_locked
        && !osc_in_pin_in;
      prog_output_enable_out <= program_mode_select_in && strap_done && !prog_locked
        && !output_enable_pin_in;
      program_strobe_out <= program_mode_select_in && strap_done && !prog_locked
        && !strobe_pin_in;
      program_supply_out <= program_mode_select_in && strap_done && !prog_locked
        && supply_pin_in;
    end
  end
endmodule

// *** bench/swo_sleep_watchdog_properties.sv ***
// Port assertions for the sleep and watchdog block
`timescale 1ns/100ps
module swo_sleep_watchdog_properties (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic op_valid_in,
  input wire logic [7:0] op_code_in,
  input wire logic stop_recovery_pin_in,
  input wire logic low_voltage_in,
  input wire logic opt_read_protect_in,
  input wire logic opt_latch_disable_in,
  input wire logic ext_read_req_in,
  input wire logic core_clk_en_out,
  input wire logic osc_enable_out,
  input wire logic stopped_out,
  input wire logic halted_out,
  input wire logic core_reset_out,
  input wire logic port_mode_default_out,
  input wire logic fetch_load_out,
  input wire logic [15:0] fetch_addr_out,
  input wire logic flags_load_out,
  input wire logic [2:0] flags_value_out,
  input wire logic watchdog_enabled_out,
  input wire logic ext_read_grant_out,
  input wire logic latch_enable_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // Ops only count once the core is out of reset and awake
  sequence run_op(logic [7:0] c);
    op_valid_in && op_code_in == c && !core_reset_out && !stopped_out && !halted_out;
  endsequence
  sequence pin_low_in_stop;
    stopped_out && !stop_recovery_pin_in && !fetch_load_out;
  endsequence
  refresh_load_a: assert property (run_op(8'h5f) |=> flags_load_out && watchdog_enabled_out)
    else $error("refresh did not load flags");
  flags_value_a: assert property (flags_load_out |-> flags_value_out == 3'b100)
    else $error("refresh flags wrong");
  stop_entry_a: assert property (run_op(8'h6f) |-> ##2 stopped_out && !osc_enable_out)
    else $error("stop not entered");
  stop_clock_a: assert property (stopped_out |-> !core_clk_en_out && !osc_enable_out)
    else $error("clock runs in stop");
  pin_wake_a: assert property (pin_low_in_stop |=> fetch_load_out)
    else $error("pin did not wake");
  wake_vector_a: assert property (fetch_load_out |-> fetch_addr_out == 16'h000c)
    else $error("wake address wrong");
  keep_modes_a: assert property (fetch_load_out |-> !port_mode_default_out)
    else $error("port modes defaulted");
  wdt_sticky_a: assert property ($fell(watchdog_enabled_out) |-> ##[0:1] core_reset_out)
    else $error("watchdog dropped");
  low_volt_a: assert property (low_voltage_in |-> ##[1:3] core_reset_out)
    else $error("no low voltage reset");
  read_block_a: assert property (opt_read_protect_in && ext_read_req_in |=> !ext_read_grant_out)
    else $error("protected read granted");
  latch_off_a: assert property (opt_latch_disable_in |=> !latch_enable_out)
    else $error("keeper still on");
endmodule
bind swo_sleep_watchdog swo_sleep_watchdog_properties u_props (.*);

// *** bench/swo_sleep_watchdog_tb.sv ***
// Self-checking bench for the sleep and watchdog block
`timescale 1ns/100ps
module swo_sleep_watchdog_tb;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic op_valid_in = 1'b0;
  logic [7:0] op_code_in = 8'hff;
  logic port2_mode_top_in = 1'b1;
  logic stop_recovery_pin_in = 1'b1;
  logic low_voltage_in = 1'b0;
  logic opt_permanent_wdt_in = 1'b0;
  logic opt_low_noise_in = 1'b0;
  logic opt_read_protect_in = 1'b0;
  logic opt_latch_disable_in = 1'b0;
  logic opt_prog_disable_in = 1'b0;
  logic program_mode_select_in = 1'b0;
  logic osc_in_pin_in = 1'b0;
  logic output_enable_pin_in = 1'b0;
  logic supply_pin_in = 1'b0;
  logic strobe_pin_in = 1'b0;
  logic ext_read_req_in = 1'b0;
  logic internal_load_req_in = 1'b0;
  logic core_clk_en_out, osc_enable_out, stopped_out, halted_out, core_reset_out;
  logic port_mode_default_out, fetch_load_out, flags_load_out, watchdog_enabled_out;
  logic low_noise_out, ext_read_grant_out, internal_load_grant_out, latch_enable_out;
  logic program_mode_out, chip_enable_out, prog_output_enable_out;
  logic program_strobe_out, program_supply_out;
  logic [15:0] fetch_addr_out;
  logic [2:0] flags_value_out;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  // Short counts keep the run small: timeout 50, reset 20 plus 18
  swo_sleep_watchdog #(.WDT_TIMEOUT_CYC(50), .POR_DELAY_CYC(20), .EXTRA_XTAL_CYC(18)) dut (.*);
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_rst(input logic val, input int lim, output int n);
    n = 0;
    do begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end while (core_reset_out !== val && n < lim);
  endtask
  task automatic do_reset(input logic [4:0] opt);
    int n;
    @(posedge ref_clk_in);
    arst_n_in <= 1'b0;
    {opt_permanent_wdt_in, opt_low_noise_in, opt_read_protect_in,
      opt_latch_disable_in, opt_prog_disable_in} <= opt;
    repeat (4) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    wait_rst(1'b0, 100, n);
  endtask
  task automatic op(input logic [7:0] c);
    @(posedge ref_clk_in);
    op_valid_in <= 1'b1;
    op_code_in <= c;
    @(posedge ref_clk_in);
    op_valid_in <= 1'b0;
    #1;
  endtask
  // Holds the pin low a few cycles and catches the one-cycle fetch pulse
  task automatic pin_wake(output logic [15:0] a, output logic d);
    a = 16'hffff;
    d = 1'b1;
    @(posedge ref_clk_in);
    stop_recovery_pin_in <= 1'b0;
    repeat (4) begin
      @(posedge ref_clk_in);
      #1;
      if (fetch_load_out === 1'b1) begin
        a = fetch_addr_out;
        d = port_mode_default_out;
      end
    end
    @(posedge ref_clk_in);
    stop_recovery_pin_in <= 1'b1;
    #1;
  endtask
  task automatic count_en(output int n);
    n = 0;
    repeat (20) begin
      @(posedge ref_clk_in);
      #1;
      n += int'(core_clk_en_out === 1'b1);
    end
  endtask
  task automatic test_watchdog();
    int n;
    op(8'h5f);
    chk("flags_load", 16'h1, 16'(flags_load_out));
    chk("flags", 16'h4, 16'(flags_value_out));
    chk("wdt_on", 16'h1, 16'(watchdog_enabled_out));
    repeat (6) begin
      repeat (40) @(posedge ref_clk_in);
      op(8'h5f);
    end
    chk("refreshed", 16'h0, 16'(core_reset_out));
    wait_rst(1'b1, 80, n);
    chk("timeout", 16'h1, 16'(n >= 45 && n <= 54));
    wait_rst(1'b0, 100, n);
    chk("wdt_rst_len", 16'h1, 16'(n >= 38 && n <= 42));
    $display("test_watchdog done");
  endtask
  task automatic test_halt();
    int n;
    logic [15:0] a;
    logic d;
    op(8'h4f);
    op(8'h5f);
    op(8'hff);
    op(8'h7f);
    repeat (100) @(posedge ref_clk_in);
    #1;
    chk("halt_pause", 16'h0, 16'(core_reset_out));
    chk("halted", 16'h1, 16'(halted_out));
    pin_wake(a, d);
    chk("halt_exit", 16'h0, 16'(halted_out));
    op(8'h5f);
    op(8'h4f);
    op(8'hff);
    op(8'h7f);
    wait_rst(1'b1, 80, n);
    chk("halt_runs", 16'h1, 16'(n <= 56));
    wait_rst(1'b0, 100, n);
    $display("test_halt done");
  endtask
  task automatic test_stop();
    logic [15:0] a;
    logic d;
    op(8'h5f);
    op(8'hff);
    op(8'h6f);
    @(posedge ref_clk_in);
    #1;
    chk("stopped", 16'h1, 16'(stopped_out));
    chk("osc_off", 16'h0, 16'(osc_enable_out));
    repeat (100) @(posedge ref_clk_in);
    #1;
    chk("stop_pause", 16'h0, 16'(core_reset_out));
    pin_wake(a, d);
    chk("wake_addr", 16'h000c, a);
    chk("keep_modes", 16'h0, 16'(d));
    chk("woken", 16'h0, 16'(stopped_out));
    $display("test_stop done");
  endtask
  task automatic test_options();
    int n;
    program_mode_select_in <= 1'b1;
    supply_pin_in <= 1'b1;
    ext_read_req_in <= 1'b1;
    internal_load_req_in <= 1'b1;
    do_reset(5'h1f);
    chk("perm_on", 16'h1, 16'(watchdog_enabled_out));
    count_en(n);
    chk("fast_clk", 16'd20, 16'(n));
    chk("ext_read", 16'h0, 16'(ext_read_grant_out));
    chk("int_load", 16'h1, 16'(internal_load_grant_out));
    chk("latch", 16'h0, 16'(latch_enable_out));
    chk("prog_lock", 16'h0, 16'(program_mode_out));
    chk("lock_supply", 16'h0, 16'(program_supply_out));
    op(8'hff);
    op(8'h6f);
    wait_rst(1'b1, 80, n);
    chk("perm_stop", 16'h1, 16'(n <= 56));
    do_reset(5'h04);
    chk("no_low_noise", 16'h0, 16'(low_noise_out));
    count_en(n);
    chk("half_clk", 16'd10, 16'(n));
    chk("latch_on", 16'h1, 16'(latch_enable_out));
    chk("prog_mode", 16'h1, 16'(program_mode_out));
    chk("chip_en", 16'h1, 16'(chip_enable_out));
    chk("prog_oe", 16'h1, 16'(prog_output_enable_out));
    chk("prog_strobe", 16'h1, 16'(program_strobe_out));
    chk("prog_supply", 16'h1, 16'(program_supply_out));
    @(posedge ref_clk_in);
    low_voltage_in <= 1'b1;
    wait_rst(1'b1, 5, n);
    chk("low_volt", 16'h1, 16'(n <= 3));
    low_voltage_in <= 1'b0;
    $display("test_options done");
  endtask
  initial begin
    do_reset(5'h00);
    test_watchdog();
    test_halt();
    test_stop();
    test_options();
    print_verdict();
  end
endmodule
